// File: sfm_pkg.sv
// constants shared by the receive framing monitor
// assumes: byte-wide registers on a plain address/strobe port
package sfm_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [15:0] STATUS_ADDR = 16'h1107;  // defect status, RO
  localparam logic [15:0] INTST_ADDR  = 16'h110b;  // change flags, RC
  localparam logic [15:0] CFG_ADDR    = 16'h1100;  // lof clear frames

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int SEF_BIT = 1;  // sef declared / sef change
  localparam int LOF_BIT = 2;  // lof declared / lof change

  // ----------------------------------------
  // reset values and widths
  // ----------------------------------------
  localparam int          DATA_W    = 8;
  localparam logic [7:0]  CFG_RESET = 8'h08;  // lof clear frame count
  localparam logic [7:0]  ZERO_BYTE = 8'h00;
  localparam logic [7:0]  ONES_BYTE = 8'hff;

  // ----------------------------------------
  // framing criteria and timing
  // ----------------------------------------
  localparam int SEF_SET_FRAMES = 4;     // errored frames to declare
  localparam int SEF_CLR_FRAMES = 2;     // clean frames to clear
  localparam int LOF_TIME_US    = 3000;  // sef persistence for lof
  localparam int CLK_MHZ        = 125;   // clk_i rate
  localparam int LOF_CYCLES     = LOF_TIME_US * CLK_MHZ;

  // ----------------------------------------
  // framing states
  // ----------------------------------------
  typedef enum logic [1:0] {
    SFM_IN_FRAME,  // sef 0, lof 0
    SFM_SEF_ONLY,  // sef 1, lof 0
    SFM_SEF_LOF,   // sef 1, lof 1
    SFM_LOF_ONLY   // sef 0, lof 1
  } sfm_state_t;

endpackage

// File: sfm_frame_monitor.sv
// receive framing monitor: sef and lof defect tracking
// assumes: one frame_i pulse per received frame, with
// frame_err_i telling whether its framing bytes were errored
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module sfm_frame_monitor #(
  parameter int LOF_CYCLES = sfm_pkg::LOF_CYCLES  // 3 ms in clocks
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // received frame stream
  input  wire logic        frame_i,
  input  wire logic        frame_err_i,
  // register port
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wr_data_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rd_data_o,
  // defect levels and interrupt
  output logic             sef_o,
  output logic             lof_o,
  output logic             irq_n_o
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  localparam int TW = $clog2(LOF_CYCLES + 1);
  localparam logic [TW-1:0] TMR_LAST = TW'(LOF_CYCLES - 1);
  localparam logic [2:0] ERR_LAST = 3'(sfm_pkg::SEF_SET_FRAMES - 1);
  localparam logic [7:0] GOOD_LAST = 8'(sfm_pkg::SEF_CLR_FRAMES - 1);
  localparam logic [7:0] GOOD_MAX = sfm_pkg::ONES_BYTE;
  localparam logic [7:0] ZERO8 = sfm_pkg::ZERO_BYTE;

  sfm_pkg::sfm_state_t state;       // framing state
  sfm_pkg::sfm_state_t next_state;
  logic [2:0]    err_cnt;           // consecutive errored frames
  logic [2:0]    next_err_cnt;
  logic [7:0]    good_cnt;          // consecutive clean frames
  logic [7:0]    next_good_cnt;
  logic [TW-1:0] tmr;               // sef persistence timer
  logic [TW-1:0] next_tmr;
  logic          next_sef;
  logic          next_lof;

  logic [7:0]    cfg;               // lof clear frame count
  logic [7:0]    next_cfg;
  logic [7:0]    int_st;            // change flags
  logic [7:0]    next_int_st;
  logic [7:0]    next_rd_data;
  logic          next_irq_n;

  logic frame_bad;                  // errored frame this cycle
  logic frame_ok;                   // clean frame this cycle
  logic err_hit;                    // this frame completes four
  logic good_hit;                   // this frame completes two
  logic lof_clr_hit;                // this frame meets cfg count
  logic tmr_hit;                    // 3 ms reached
  logic sef_chg;                    // sef about to change
  logic lof_chg;                    // lof about to change

  // ----------------------------------------
  // frame classification
  // ----------------------------------------
  always_comb begin
    frame_bad   = frame_i & frame_err_i;
    frame_ok    = frame_i & ~frame_err_i;
    err_hit     = frame_bad && (err_cnt >= ERR_LAST);
    good_hit    = frame_ok && (good_cnt >= GOOD_LAST);
    // a count of zero behaves as one frame
    lof_clr_hit = frame_ok && ((good_cnt + 8'h01) >= cfg);
    tmr_hit     = (tmr >= TMR_LAST);
  end

  // ----------------------------------------
  // framing state, counters and timer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    // counters saturate so a long run never wraps back
    if (frame_bad) begin
      next_err_cnt  = (err_cnt == ERR_LAST) ? err_cnt : err_cnt + 3'h1;
      next_good_cnt = ZERO8;
    end else if (frame_ok) begin
      next_err_cnt  = 3'h0;
      next_good_cnt = (good_cnt == GOOD_MAX) ? good_cnt : good_cnt + 8'h01;
    end else begin
      next_err_cnt  = err_cnt;
      next_good_cnt = good_cnt;
    end
    next_tmr = '0;
    unique case (state)
      sfm_pkg::SFM_IN_FRAME: begin
        // occasional errors are tolerated
        if (err_hit) begin
          next_state = sfm_pkg::SFM_SEF_ONLY;
        end
      end
      sfm_pkg::SFM_SEF_ONLY: begin
        // two clean frames return to in-frame, else the timer runs on each clock toward lof
        if (good_hit) begin
          next_state = sfm_pkg::SFM_IN_FRAME;
        end else if (tmr_hit) begin
          next_state = sfm_pkg::SFM_SEF_LOF;
        end else begin
          next_tmr = tmr + TW'(1);
        end
      end
      sfm_pkg::SFM_SEF_LOF: begin
        // clean frames clear sef but lof stays
        if (good_hit) begin
          next_state = sfm_pkg::SFM_LOF_ONLY;
        end
      end
      sfm_pkg::SFM_LOF_ONLY: begin
        // errored run re-declares sef before lof can clear
        if (err_hit) begin
          next_state = sfm_pkg::SFM_SEF_LOF;
        end else if (lof_clr_hit) begin
          next_state = sfm_pkg::SFM_IN_FRAME;
        end
      end
    endcase
    // each new state counts afresh
    if (next_state != state) begin
      next_err_cnt  = 3'h0;
      next_good_cnt = ZERO8;
    end
    next_sef = (next_state == sfm_pkg::SFM_SEF_ONLY) ||
               (next_state == sfm_pkg::SFM_SEF_LOF);
    next_lof = (next_state == sfm_pkg::SFM_SEF_LOF) ||
               (next_state == sfm_pkg::SFM_LOF_ONLY);
    sef_chg  = next_sef != sef_o;
    lof_chg  = next_lof != lof_o;
  end

  // state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= sfm_pkg::SFM_IN_FRAME;
      err_cnt  <= 3'h0;
      good_cnt <= ZERO8;
      tmr      <= '0;
      sef_o    <= 1'b0;
      lof_o    <= 1'b0;
    end else begin
      state    <= next_state;
      err_cnt  <= next_err_cnt;
      good_cnt <= next_good_cnt;
      tmr      <= next_tmr;
      sef_o    <= next_sef;
      lof_o    <= next_lof;
    end
  end

  // ----------------------------------------
  // register port and change flags
  // ----------------------------------------
  always_comb begin
    next_cfg     = cfg;
    next_rd_data = ZERO8;
    next_int_st  = int_st;
    if (wr_i && (addr_i == sfm_pkg::CFG_ADDR)) begin
      next_cfg = wr_data_i;
    end
    // reading the flags clears them
    if (rd_i && (addr_i == sfm_pkg::INTST_ADDR)) begin
      next_int_st = ZERO8;
    end
    // a change in the same cycle as the read is kept
    if (sef_chg) begin
      next_int_st[sfm_pkg::SEF_BIT] = 1'b1;
    end
    if (lof_chg) begin
      next_int_st[sfm_pkg::LOF_BIT] = 1'b1;
    end
    if (rd_i) begin
      unique case (addr_i)
        sfm_pkg::STATUS_ADDR: begin
          next_rd_data[sfm_pkg::SEF_BIT] = sef_o;
          next_rd_data[sfm_pkg::LOF_BIT] = lof_o;
        end
        sfm_pkg::INTST_ADDR: next_rd_data = int_st;
        sfm_pkg::CFG_ADDR:   next_rd_data = cfg;
        default:             next_rd_data = ZERO8;  // unmapped
      endcase
    end
    // irq low while any flag stands
    next_irq_n = ~(|next_int_st);
  end

  // register port state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg       <= sfm_pkg::CFG_RESET;
      int_st    <= ZERO8;
      rd_data_o <= ZERO8;
      irq_n_o   <= 1'b1;
    end else begin
      cfg       <= next_cfg;
      int_st    <= next_int_st;
      rd_data_o <= next_rd_data;
      irq_n_o   <= next_irq_n;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // second clean frame while sef only
  sequence s_second_good;
    (state == sfm_pkg::SFM_SEF_ONLY) && frame_ok && (good_cnt == GOOD_LAST);
  endsequence

  // fourth errored frame while in frame
  sequence s_fourth_bad;
    (state == sfm_pkg::SFM_IN_FRAME) && frame_bad && (err_cnt == ERR_LAST);
  endsequence

  sef_exit_path_a: assert property (
    (state == sfm_pkg::SFM_SEF_ONLY) |=> (state != sfm_pkg::SFM_LOF_ONLY))
    else $error("sef only state left to lof only");

  sef_clear_a: assert property (
    s_second_good |=> !sef_o && !lof_o ##0 int_st[sfm_pkg::SEF_BIT])
    else $error("sef not cleared by two clean frames");

  lof_timer_a: assert property (
    (state == sfm_pkg::SFM_SEF_ONLY) && (tmr == TMR_LAST) && !good_hit
    |=> lof_o && sef_o)
    else $error("lof not declared at 3 ms");

  sef_hold_a: assert property (
    (state == sfm_pkg::SFM_SEF_ONLY) && frame_bad && !tmr_hit
    |=> sef_o && (tmr == $past(tmr) + TW'(1)))
    else $error("sef or timer lost on errored frame");

  sef_declare_a: assert property (
    s_fourth_bad |=> sef_o && !lof_o)
    else $error("sef not declared after four errored frames");

  status_read_a: assert property (
    rd_i && (addr_i == sfm_pkg::STATUS_ADDR)
    |=> rd_data_o[sfm_pkg::SEF_BIT] == $past(sef_o))
    else $error("status sef bit does not track sef");

  sef_change_irq_a: assert property (
    $changed(sef_o) |-> int_st[sfm_pkg::SEF_BIT] && !irq_n_o)
    else $error("sef change did not raise interrupt");

  lof_declare_a: assert property (
    $rose(lof_o) |-> int_st[sfm_pkg::LOF_BIT] && !irq_n_o)
    else $error("lof declare did not raise interrupt");

  lof_clear_a: assert property (
    (state == sfm_pkg::SFM_LOF_ONLY) && lof_clr_hit
    |=> !lof_o && !sef_o && int_st[sfm_pkg::LOF_BIT] && (state == sfm_pkg::SFM_IN_FRAME))
    else $error("lof not cleared at selected count");

  read_clear_a: assert property (
    rd_i && (addr_i == sfm_pkg::INTST_ADDR) && !sef_chg && !lof_chg
    |=> (int_st == ZERO8) && irq_n_o)
    else $error("flags not cleared by read");

  count_restart_a: assert property (
    frame_ok |=> (err_cnt == 3'h0))
    else $error("errored run not restarted by clean frame");

  // the interrupt pin mirrors whether any flag stands
  irq_level_a: assert property (
    irq_n_o == (int_st == ZERO8))
    else $error("interrupt level does not follow the flags");

  // read data stands only in the cycle after a read strobe
  read_idle_a: assert property (
    !rd_i |=> (rd_data_o == ZERO8))
    else $error("read data seen outside its answer cycle");

  // a negated sef reads back as zero in the status byte
  status_zero_a: assert property (
    rd_i && (addr_i == sfm_pkg::STATUS_ADDR) && !sef_o
    |=> !rd_data_o[sfm_pkg::SEF_BIT])
    else $error("status sef bit set while sef negated");

endmodule

`default_nettype wire

// File: sfm_frame_src.sv
// far-side model: the received line, reduced to one pulse per frame
// assumes: the bench calls send_frames from its own process
`timescale 1ns/100ps
`default_nettype none

module sfm_frame_src (
  // clock
  input  wire logic clk_i,
  // frame stream toward the monitor
  output var  logic frame_o,
  output var  logic frame_err_o
);
  // ----------------------------------------
  // frame generator
  // ----------------------------------------
  initial begin
    frame_o     = 1'b0;
    frame_err_o = 1'b1;
  end

  // n frames of one kind, one clock each, gap + 1 idle cycles after each
  // outside a frame the error line shows the inverse of its last value,
  // so a monitor that samples it without frame_o would be caught out
  task automatic send_frames(input int n, input logic err, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      frame_o     <= 1'b1;
      frame_err_o <= err;
      @(posedge clk_i);
      frame_o     <= 1'b0;
      frame_err_o <= ~err;
      repeat (gap) @(posedge clk_i);
    end
  endtask
endmodule

`default_nettype wire

// File: sfm_frame_monitor_tb.sv
// self-checking bench for the receive framing monitor
// assumes: lof timer shortened to 20 clocks, frames from sfm_frame_src
`timescale 1ns/100ps
`default_nettype none

module sfm_frame_monitor_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int LOFC = 20;  // short lof persistence, clocks
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        frame_i;
  logic        frame_err_i;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0]  wr_data_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [7:0]  rd_data_o;
  logic        sef_o;
  logic        lof_o;
  logic        irq_n_o;
  logic [7:0]  rv;       // last read value
  int          n_fail = 0;
  int          compares = 0;

  always #4 clk_i = ~clk_i;  // 125 MHz

  sfm_frame_monitor #(.LOF_CYCLES(LOFC)) sfm_frame_monitor_inst (
    .clk_i(clk_i), .rst_i(rst_i), .frame_i(frame_i), .frame_err_i(frame_err_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .sef_o(sef_o), .lof_o(lof_o), .irq_n_o(irq_n_o));

  sfm_frame_src sfm_frame_src_inst (.clk_i(clk_i), .frame_o(frame_i), .frame_err_o(frame_err_i));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1; addr_i <= a; wr_data_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe edge
  task automatic rd(input logic [15:0] a);
    @(posedge clk_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rv = rd_data_o;
  endtask

  task automatic lvl(input logic s, input logic l, input logic [7:0] st);
    #1;
    chk("sef_o", {7'h00, sef_o}, {7'h00, s});
    chk("lof_o", {7'h00, lof_o}, {7'h00, l});
    rd(sfm_pkg::STATUS_ADDR); chk("status", rv, st);
  endtask

  task automatic tally_and_finish();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_map();
    rd(sfm_pkg::STATUS_ADDR); chk("status rst", rv, 8'h00);
    rd(sfm_pkg::INTST_ADDR); chk("intst rst", rv, 8'h00);
    rd(sfm_pkg::CFG_ADDR); chk("cfg rst", rv, sfm_pkg::CFG_RESET);
    chk("irq rst", {7'h00, irq_n_o}, 8'h01);
    wr(sfm_pkg::STATUS_ADDR, 8'hff); rd(sfm_pkg::STATUS_ADDR); chk("status ro", rv, 8'h00);
    wr(16'h1234, 8'h5a); rd(16'h1234); chk("unmapped", rv, 8'h00);
  endtask

  task automatic t_sef_set();
    sfm_frame_src_inst.send_frames(3, 1'b1, 0);
    sfm_frame_src_inst.send_frames(1, 1'b0, 2);
    sfm_frame_src_inst.send_frames(3, 1'b1, 1);
    lvl(1'b0, 1'b0, 8'h00);
    sfm_frame_src_inst.send_frames(1, 1'b1, 0);
    #1 chk("irq set", {7'h00, irq_n_o}, 8'h00);
    lvl(1'b1, 1'b0, 8'h02);
    rd(sfm_pkg::INTST_ADDR); chk("intst sef", rv, 8'h02);
    chk("irq rel", {7'h00, irq_n_o}, 8'h01);
    rd(sfm_pkg::INTST_ADDR); chk("intst clr", rv, 8'h00);
  endtask

  task automatic t_sef_clear();
    sfm_frame_src_inst.send_frames(1, 1'b0, 0);
    sfm_frame_src_inst.send_frames(1, 1'b1, 0);
    sfm_frame_src_inst.send_frames(1, 1'b0, 0);
    lvl(1'b1, 1'b0, 8'h02);
    sfm_frame_src_inst.send_frames(1, 1'b0, 0);
    #1 chk("irq clr", {7'h00, irq_n_o}, 8'h00);
    lvl(1'b0, 1'b0, 8'h00);
    rd(sfm_pkg::INTST_ADDR); chk("intst sef clr", rv, 8'h02);
  endtask

  task automatic t_lof();
    int k;
    sfm_frame_src_inst.send_frames(4, 1'b1, 0);
    sfm_frame_src_inst.send_frames(3, 1'b1, 4);
    #1 chk("lof early", {7'h00, lof_o}, 8'h00);
    k = 0;
    while (lof_o !== 1'b1 && k < 2 * LOFC) begin
      sfm_frame_src_inst.send_frames(1, 1'b1, 0);
      #1;
      k++;
    end
    if (k >= 2 * LOFC) begin
      n_fail++;
      tally_and_finish();
    end
    lvl(1'b1, 1'b1, 8'h06);
    rd(sfm_pkg::INTST_ADDR); chk("intst lof", rv, 8'h06);
  endtask

  task automatic t_lof_clear();
    wr(sfm_pkg::CFG_ADDR, 8'h03);
    rd(sfm_pkg::CFG_ADDR); chk("cfg rw", rv, 8'h03);
    sfm_frame_src_inst.send_frames(2, 1'b0, 0);
    lvl(1'b0, 1'b1, 8'h04);
    sfm_frame_src_inst.send_frames(2, 1'b0, 1);
    lvl(1'b0, 1'b1, 8'h04);
    sfm_frame_src_inst.send_frames(1, 1'b0, 0);
    lvl(1'b0, 1'b0, 8'h00);
    rd(sfm_pkg::INTST_ADDR); chk("intst lof clr", rv, 8'h06);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_map();
    t_sef_set();
    t_sef_clear();
    t_lof();
    t_lof_clear();
    tally_and_finish();
  end

  // watchdog against a hung run
  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
